/* verilog/dac10_control.v */
// Register file and digital control for four 10-bit converter channels.
// Assumes a simple strobe bus synchronous to clk_sys_i; the analog
// ladder, pin switches and pin input buffers sit outside.
// Pin inputs are taken as already synchronous to clk_sys_i, so the
// read-back has one flop and no synchroniser.
//
// What this block does
// - Control bit 7 enables the channel; zero disables it.
// - Control bit 6 picks left (one) or right (zero) justified code.
// - Control bit 5 connects the level to pin one.
// - Control bit 4 connects the level to pin two.
// - Bits 3-2 pick supply, ext zero, fixed, or ext one (upper channels).
// - Bits 1-0 pick ground, ext zero, ext one (upper channels), else reserved.
// - High register holds code 9..2 left, or 9..8 right with zeros above.
// - Low register holds code 1..0 in top bits left, or 7..0 right.
// - Writing one to a load bit copies the code, then hardware clears it.
// - A zero load bit leaves the buffered code untouched.
// - Load bits sit at 0, 1, 4 and 5 for channels a to d.
// - Load bits 7-6 and 3-2 read zero and ignore writes.
// - Every implemented register bit clears on any reset.
// - Code writes do not reach the ladder until a load.
// - A pin carrying the level reads back as zero.
// - Reset disables channels, frees the pins and clears all code bits.
`timescale 1ns/100ps
`include "dac10_control_regs.vh"

module dac10_control (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rstn_i,
  // Register port
  input  wire [3:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output wire [7:0]  reg_rdata_o,
  // Pin digital inputs and their read-back, two pins per channel
  input  wire [7:0]  pin_in_i,
  output wire [7:0]  pin_read_o,
  // Channel controls toward the analog side
  output wire [3:0]  chan_enable_o,
  output wire [3:0]  level_pin_one_o,
  output wire [3:0]  level_pin_two_o,
  // Buffered ladder settings, channel a in the low bits
  output wire [39:0] code_o,
  output wire [15:0] pos_sel_o,
  output wire [11:0] neg_sel_o,
  output wire [3:0]  select_reserved_o
);

  // ==========================================================
  // Helpers
  function addr_hit;
    input [3:0] addr;
    input [3:0] base;
    input [3:0] ch;
    begin
      addr_hit = (addr == (base + ch));
    end
  endfunction

  function [7:0] byte_sel;
    input [31:0] vec;
    input [1:0]  idx;
    begin
      case (idx)
        2'h0:    byte_sel = vec[7:0];
        2'h1:    byte_sel = vec[15:8];
        2'h2:    byte_sel = vec[23:16];
        default: byte_sel = vec[31:24];
      endcase
    end
  endfunction

  function [2:0] load_pos;
    input [1:0] ch;
    begin
      case (ch)
        2'h0:    load_pos = `LD_POS_A;
        2'h1:    load_pos = `LD_POS_B;
        2'h2:    load_pos = `LD_POS_C;
        default: load_pos = `LD_POS_D;
      endcase
    end
  endfunction

  // Genvar to a 4-bit channel number without a silent width cut
  function [3:0] chan_idx;
    input integer n;
    begin
      case (n)
        0:       chan_idx = 4'h0;
        1:       chan_idx = 4'h1;
        2:       chan_idx = 4'h2;
        default: chan_idx = 4'h3;
      endcase
    end
  endfunction

  // Only the four implemented load bits exist, on write and on read
  function [7:0] load_mask;
    input [7:0] v;
    begin
      load_mask = v & `LD_IMPL_MASK;
    end
  endfunction

  // Read-back of one pin under its drive bit
  function pin_view;
    input drive;
    input level;
    begin
      pin_view = drive ? 1'b0 : level;
    end
  endfunction

  // ==========================================================
  // Shared load register
  reg  [7:0]  load_q;
  wire [7:0]  load_d;
  wire        wr_load;

  assign wr_load = reg_wr_i && (reg_addr_i == `OFF_LOAD);

  // A load bit lives for one cycle, fires, and is cleared by hardware.
  // A write landing in the clearing cycle wins, so no request is lost.
  assign load_d = wr_load ? load_mask(reg_wdata_i) : `RST_LOAD;

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      load_q <= `RST_LOAD;
    end else begin
      load_q <= load_d;
    end
  end

  // ==========================================================
  // Per-channel registers
  wire [31:0] ctrl_all;
  wire [31:0] high_rd_all;
  wire [31:0] low_rd_all;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_ch
      localparam [3:0] CH = chan_idx(i);

      reg  [7:0] ctrl_q;
      reg  [7:0] high_q;
      reg  [7:0] low_q;
      reg  [9:0] code_buf_q;
      reg  [3:0] pos_q;
      reg  [2:0] neg_q;
      reg        rsvd_q;
      wire [9:0] code_new;
      wire [7:0] high_rd;
      wire [7:0] low_rd;
      wire [3:0] pos_new;
      wire [2:0] neg_new;
      wire       rsvd_new;
      wire       fire;
      wire       wr_ctrl;
      wire       wr_high;
      wire       wr_low;
      wire       justify_format;
      wire       pin_one_drive;
      wire       pin_two_drive;
      wire [1:0] positive_source_select;
      wire [1:0] negative_source_select;
      reg  [1:0] pin_rd_q;

      assign fire = load_q[load_pos(CH[1:0])];

      // Write decode, one strobe per register of this channel
      assign wr_ctrl = reg_wr_i && addr_hit(reg_addr_i, `OFF_CTRL_BASE, CH);
      assign wr_high = reg_wr_i && addr_hit(reg_addr_i, `OFF_HIGH_BASE, CH);
      assign wr_low  = reg_wr_i && addr_hit(reg_addr_i, `OFF_LOW_BASE, CH);

      // Named control fields
      assign justify_format         = ctrl_q[`CTRL_FM_BIT];
      assign pin_one_drive          = ctrl_q[`CTRL_OE1_BIT];
      assign pin_two_drive          = ctrl_q[`CTRL_OE2_BIT];
      assign positive_source_select = ctrl_q[`CTRL_PSS_HI:`CTRL_PSS_LO];
      assign negative_source_select = ctrl_q[`CTRL_NSS_HI:`CTRL_NSS_LO];

      // ==========================================================
      // Register writes
      always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          ctrl_q <= `RST_CTRL;
          high_q <= `RST_CODE;
          low_q  <= `RST_CODE;
        end else begin
          if (wr_ctrl) begin
            ctrl_q <= reg_wdata_i;
          end
          // Staged only; the ladder sees nothing until a load
          if (wr_high) begin
            high_q <= reg_wdata_i;
          end
          if (wr_low) begin
            low_q <= reg_wdata_i;
          end
        end
      end

      dac10_code_pack u_pack (
        .high_i           (high_q),
        .low_i            (low_q),
        .justify_format_i (justify_format),
        .code_o           (code_new),
        .high_rd_o        (high_rd),
        .low_rd_o         (low_rd)
      );

      dac10_source_decode #(
        .UPPER (i / 2)
      ) u_decode (
        .positive_source_select_i (positive_source_select),
        .negative_source_select_i (negative_source_select),
        .pos_sel_o                (pos_new),
        .neg_sel_o                (neg_new),
        .reserved_o               (rsvd_new)
      );

      // ==========================================================
      // Double buffer: all ten bits and the selects move together
      // Selects are buffered too, so a control byte written between
      // loads never swaps the ladder ends under a running code.
      always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          code_buf_q <= `RST_BUF;
          pos_q      <= 4'h0;
          neg_q      <= 3'h0;
          rsvd_q     <= 1'b0;
        end else if (fire) begin
          code_buf_q <= code_new;
          pos_q      <= pos_new;
          neg_q      <= neg_new;
          rsvd_q     <= rsvd_new;
        end else begin
          code_buf_q <= code_buf_q;
        end
      end

      // ==========================================================
      // A pin handed to the level has no digital path back
      always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          pin_rd_q <= 2'h0;
        end else begin
          pin_rd_q[0] <= pin_view(pin_one_drive, pin_in_i[2*i]);
          pin_rd_q[1] <= pin_view(pin_two_drive, pin_in_i[2*i+1]);
        end
      end

      // ==========================================================
      // Toward the analog side and the pin read-back
      assign chan_enable_o[i]     = ctrl_q[`CTRL_EN_BIT];
      assign level_pin_one_o[i]   = pin_one_drive;
      assign level_pin_two_o[i]   = pin_two_drive;
      assign pin_read_o[2*i+1:2*i] = pin_rd_q;
      assign code_o[10*i+9:10*i]  = code_buf_q;
      assign pos_sel_o[4*i+3:4*i] = pos_q;
      assign neg_sel_o[3*i+2:3*i] = neg_q;
      assign select_reserved_o[i] = rsvd_q;

      assign ctrl_all[8*i+7:8*i]    = ctrl_q;
      assign high_rd_all[8*i+7:8*i] = high_rd;
      assign low_rd_all[8*i+7:8*i]  = low_rd;
    end
  endgenerate

  // ==========================================================
  // Read path
  reg  [7:0] rd_val;
  reg  [7:0] rdata_q;

  // Unmapped offsets read zero; unimplemented code bits are masked
  always @* begin
    case (reg_addr_i[3:2])
      2'h0:    rd_val = byte_sel(ctrl_all, reg_addr_i[1:0]);
      2'h1:    rd_val = byte_sel(high_rd_all, reg_addr_i[1:0]);
      2'h2:    rd_val = byte_sel(low_rd_all, reg_addr_i[1:0]);
      default: rd_val = (reg_addr_i == `OFF_LOAD) ? load_mask(load_q) : 8'h00;
    endcase
  end

  // Reads have no side effects; a load bit clears on its own.
  // Data stand only in the cycle after the read strobe
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd_i ? rd_val : 8'h00;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule

/* verilog/dac10_control_regs.vh */
// Register offsets, field positions, reset values and select codes
// for the four-channel 10-bit converter control block.
// Assumes byte-wide registers on a 4-bit address port.
`ifndef DAC10_CONTROL_REGS_VH
`define DAC10_CONTROL_REGS_VH

// ==========================================================
// Register offsets (channel index is added to each base)
`define OFF_CTRL_BASE   4'h0
`define OFF_HIGH_BASE   4'h4
`define OFF_LOW_BASE    4'h8
`define OFF_LOAD        4'hC

// ==========================================================
// Control register fields
`define CTRL_EN_BIT     7
`define CTRL_FM_BIT     6
`define CTRL_OE1_BIT    5
`define CTRL_OE2_BIT    4
`define CTRL_PSS_HI     3
`define CTRL_PSS_LO     2
`define CTRL_NSS_HI     1
`define CTRL_NSS_LO     0

// ==========================================================
// Load register fields
`define LD_POS_A        3'h0
`define LD_POS_B        3'h1
`define LD_POS_C        3'h4
`define LD_POS_D        3'h5
`define LD_IMPL_MASK    8'h33

// ==========================================================
// Reset values
`define RST_CTRL        8'h00
`define RST_CODE        8'h00
`define RST_LOAD        8'h00
`define RST_BUF         10'h000

// ==========================================================
// Source select codes
`define PSS_SUPPLY      2'h0
`define PSS_EXT_ZERO    2'h1
`define PSS_FIXED       2'h2
`define PSS_EXT_ONE     2'h3
`define NSS_GROUND      2'h0
`define NSS_EXT_ZERO    2'h1
`define NSS_EXT_ONE     2'h2

`endif

/* verilog/dac10_code_pack.v */
// Assembles the 10-bit code from the high and low code registers,
// and gives the read-back view of both, under the format bit.
// Purely combinational; the caller registers what it needs.
`timescale 1ns/100ps

module dac10_code_pack (
  // Staged code registers
  input  wire [7:0] high_i,
  input  wire [7:0] low_i,
  // Format: one is left justified
  input  wire       justify_format_i,
  // Results
  output reg  [9:0] code_o,
  output reg  [7:0] high_rd_o,
  output reg  [7:0] low_rd_o
);

  // ==========================================================
  // Justification
  always @* begin
    if (justify_format_i) begin
      code_o    = {high_i, low_i[7:6]};
      high_rd_o = high_i;
      low_rd_o  = {low_i[7:6], 6'h00};
    end else begin
      code_o    = {high_i[1:0], low_i};
      high_rd_o = {6'h00, high_i[1:0]};
      low_rd_o  = low_i;
    end
  end

endmodule

/* verilog/dac10_source_decode.v */
// Decodes the positive and negative source fields into one-hot
// selects toward the ladder ends. Reserved codes select nothing.
// UPPER is one for the third and fourth channels.
`timescale 1ns/100ps
`include "dac10_control_regs.vh"

module dac10_source_decode #(
  parameter UPPER = 0
) (
  // Fields
  input  wire [1:0] positive_source_select_i,
  input  wire [1:0] negative_source_select_i,
  // One-hot: supply, ext zero, fixed, ext one
  output reg  [3:0] pos_sel_o,
  // One-hot: ground, ext zero, ext one
  output reg  [2:0] neg_sel_o,
  output reg        reserved_o
);

  // ==========================================================
  // Decode
  always @* begin
    pos_sel_o  = 4'h0;
    neg_sel_o  = 3'h0;
    reserved_o = 1'b0;
    case (positive_source_select_i)
      `PSS_SUPPLY:   pos_sel_o = 4'h1;
      `PSS_EXT_ZERO: pos_sel_o = 4'h2;
      `PSS_FIXED:    pos_sel_o = 4'h4;
      default: begin
        if (UPPER != 0) pos_sel_o = 4'h8;
        else reserved_o = 1'b1;
      end
    endcase
    case (negative_source_select_i)
      `NSS_GROUND:   neg_sel_o = 3'h1;
      `NSS_EXT_ZERO: neg_sel_o = 3'h2;
      `NSS_EXT_ONE: begin
        if (UPPER != 0) neg_sel_o = 3'h4;
        else reserved_o = 1'b1;
      end
      default: reserved_o = 1'b1;
    endcase
  end

endmodule

/* dv/dac10_control_asserts.sv */
// Port checker for the four-channel converter control block.
// Assumes the address map 0x0-0xC and a two-edge load path.
`timescale 1ns/100ps
module dac10_control_asserts (
  // Clock, reset and register port
  input wire        clk_sys_i,
  input wire        rstn_i,
  input wire [3:0]  reg_addr_i,
  input wire [7:0]  reg_wdata_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [7:0]  reg_rdata_o,
  // Pins and ladder side
  input wire [7:0]  pin_in_i,
  input wire [7:0]  pin_read_o,
  input wire [3:0]  chan_enable_o,
  input wire [3:0]  level_pin_one_o,
  input wire [3:0]  level_pin_two_o,
  input wire [39:0] code_o,
  input wire [15:0] pos_sel_o,
  input wire [11:0] neg_sel_o,
  input wire [3:0]  select_reserved_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  wire       ctl_wr = reg_wr_i && reg_addr_i < 4'h4;
  wire       ld_wr  = reg_wr_i && reg_addr_i == 4'hC;
  wire       ld_any = ld_wr && (reg_wdata_i & 8'h33) != 8'h00;
  wire       ld_rd  = reg_rd_i && reg_addr_i == 4'hC;
  wire [7:0] drv    = {level_pin_two_o[3], level_pin_one_o[3], level_pin_two_o[2], level_pin_one_o[2],
                       level_pin_two_o[1], level_pin_one_o[1], level_pin_two_o[0], level_pin_one_o[0]};
  sequence s_ld_then_rd; ld_wr ##1 ld_rd; endsequence
  sequence s_ld_gap_rd; ld_wr ##1 !ld_wr [*2] ##1 ld_rd; endsequence

  // ==========================================
  // Checks
  a_enable_write: assert property (ctl_wr |=>
    chan_enable_o[$past(reg_addr_i[1:0])] == $past(reg_wdata_i[7])) else $error("enable wrong");
  a_pin_one_write: assert property (ctl_wr |=>
    level_pin_one_o[$past(reg_addr_i[1:0])] == $past(reg_wdata_i[5])) else $error("pin one wrong");
  a_pin_two_write: assert property (ctl_wr |=>
    level_pin_two_o[$past(reg_addr_i[1:0])] == $past(reg_wdata_i[4])) else $error("pin two wrong");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn_i |->
    {chan_enable_o, level_pin_one_o, level_pin_two_o} == 12'h000 && code_o == 40'h0) else $error("reset leak");
  a_pin_masked: assert property ($past(rstn_i) |->
    pin_read_o == ($past(pin_in_i) & ~$past(drv))) else $error("pin read wrong");
  a_buffer_hold: assert property ($changed(code_o) || $changed(pos_sel_o) || $changed(neg_sel_o) |->
    $past(ld_any, 2)) else $error("buffer moved");
  a_load_bit_set: assert property (s_ld_then_rd |=>
    reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h33)) else $error("load bit wrong");
  a_load_self_clear: assert property (s_ld_gap_rd |=> reg_rdata_o == 8'h00) else $error("load stuck");
  a_lower_no_ext: assert property (!pos_sel_o[3] && !pos_sel_o[7] && !neg_sel_o[2] && !neg_sel_o[5])
    else $error("reserved select");
endmodule

bind dac10_control dac10_control_asserts dac10_control_asserts_inst (
  .clk_sys_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pin_in_i,
  .pin_read_o, .chan_enable_o, .level_pin_one_o, .level_pin_two_o, .code_o, .pos_sel_o, .neg_sel_o,
  .select_reserved_o);

/* dv/dac10_control_tb.sv */
// Self-checking bench for the converter control block.
// Assumes the address map 0x0-0xC and read data one cycle late.
`timescale 1ns/100ps
module dac10_control_tb;
  reg        clk_sys_i, rstn_i, wr, rd;
  reg  [3:0] ad;
  reg  [7:0] wd, pin, rq, v, m;
  wire [7:0] rdat, prd;
  wire [3:0] en, l1, l2, rsv;
  wire [39:0] code;
  wire [15:0] ps;
  wire [11:0] ns;
  reg  [7:0] ct [4], hi [4], lo [4];
  reg  [9:0] ec [4];
  reg  [3:0] ep [4];
  reg  [2:0] eg [4];
  reg        er [4];
  int        n_errors, n_compared, seed, i, j, c;

  dac10_control dac10_control_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(ad),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .pin_in_i(pin),
    .pin_read_o(prd), .chan_enable_o(en), .level_pin_one_o(l1), .level_pin_two_o(l2),
    .code_o(code), .pos_sel_o(ps), .neg_sel_o(ns), .select_reserved_o(rsv));

  // ==========================================
  // Expectations
  function [3:0] fpos(input [1:0] ch, input [1:0] p);
    fpos = (p == 2'h3 && ch < 2) ? 4'h0 : 4'h1 << p;
  endfunction
  function [2:0] fneg(input [1:0] ch, input [1:0] n);
    fneg = (n == 2'h3 || (n == 2'h2 && ch < 2)) ? 3'h0 : 3'h1 << n;
  endfunction

  // ==========================================
  // Tasks
  task chk(input string nm, input [39:0] s, input [39:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wrap_up;
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Entered just after an edge; holds the cycle up to the next edge
  task bus(input w, input r, input [3:0] a, input [7:0] d);
    wr <= w;
    rd <= r;
    ad <= a;
    wd <= d;
    @(posedge clk_sys_i);
    rq = rdat;
  endtask
  task rdc(input [3:0] a, input [7:0] e);
    bus(0, 1, a, 8'h00);
    bus(0, 0, 4'h0, 8'h00);
    chk("read", rq, e);
  endtask
  task clr;
    for (j = 0; j < 4; j++) {ct[j], hi[j], lo[j], ec[j], ep[j], eg[j], er[j]} = 0;
  endtask
  // Load bits sit at 0, 1, 4, 5; format in force now is used
  task ldm(input [7:0] mk);
    for (j = 0; j < 4; j++)
      if (mk[j + (j & 2)]) begin
        ec[j] = ct[j][6] ? {hi[j], lo[j][7:6]} : {hi[j][1:0], lo[j]};
        ep[j] = fpos(j[1:0], ct[j][3:2]);
        eg[j] = fneg(j[1:0], ct[j][1:0]);
        er[j] = ep[j] == 4'h0 || eg[j] == 3'h0;
      end
  endtask
  task outs;
    for (j = 0; j < 4; j++) begin
      chk("code", code[10*j +: 10], ec[j]);
      chk("pos", ps[4*j +: 4], ep[j]);
      chk("neg", ns[3*j +: 3], eg[j]);
      chk("rsv", rsv[j], er[j]);
      chk("en", en[j], ct[j][7]);
      chk("pin1", l1[j], ct[j][5]);
      chk("pin2", l2[j], ct[j][4]);
    end
  endtask

  // ==========================================
  // Clock, watchdog, sequence
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // Planned run is near 1000 cycles; allow ample margin
  initial begin
    #100000;
    n_errors++;
    wrap_up;
  end
  initial begin
    {rstn_i, wr, rd, ad, wd, pin} = 0;
    seed = 53;
    clr;
    repeat (16) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    for (i = 0; i < 16; i++) rdc(i, 8'h00);
    // Unmapped places take no write
    for (i = 13; i < 16; i++) begin
      bus(1, 0, i, 8'hFF);
      rdc(i, 8'h00);
    end
    // Every select code on every channel, random rest
    for (i = 0; i < 64; i++) begin
      c = i[1:0];
      v = $random(seed);
      v[3:0] = i[5:2];
      ct[c] = v;
      hi[c] = $random(seed);
      lo[c] = $random(seed);
      bus(1, 0, c, ct[c]);
      bus(1, 0, 4 + c, hi[c]);
      bus(1, 0, 8 + c, lo[c]);
      rdc(c, ct[c]);
      rdc(4 + c, ct[c][6] ? hi[c] : {6'h00, hi[c][1:0]});
      rdc(8 + c, ct[c][6] ? {lo[c][7:6], 6'h00} : lo[c]);
      outs;
      m = $random(seed);
      bus(1, 0, 4'hC, m);
      ldm(m);
      bus(0, 0, 4'h0, 8'h00);
      bus(0, 0, 4'h0, 8'h00);
      outs;
      rdc(4'hC, 8'h00);
    end
    // Load read back in the very next cycle
    bus(1, 0, 4'hC, 8'hFF);
    ldm(8'hFF);
    bus(0, 1, 4'hC, 8'h00);
    bus(0, 0, 4'h0, 8'h00);
    chk("load", rq, 8'h33);
    outs;
    pin <= $random(seed);
    bus(0, 0, 4'h0, 8'h00);
    bus(0, 0, 4'h0, 8'h00);
    for (j = 0; j < 4; j++) v[2*j +: 2] = pin[2*j +: 2] & ~{ct[j][4], ct[j][5]};
    chk("pinrd", prd, v);
    // Reset in mid-run
    rstn_i <= 1'b0;
    clr;
    bus(0, 0, 4'h0, 8'h00);
    outs;
    rstn_i <= 1'b1;
    for (i = 0; i < 13; i++) rdc(i, 8'h00);
    wrap_up;
  end
endmodule
